// file: rtl/cgm_mode_sel.sv
// Mode selector of the clock generator: decodes software fields into a mode,
// drives clock mux selects and PLL/FLL enables, and serves a Wishbone register file.
// Assumes the analog clock muxes, PLL, FLL and oscillator sit outside and obey the
// select and enable outputs; the debug request arrives asynchronously on a pin.
`timescale 1ns/1ps
`default_nettype none
module cgm_mode_sel #(
    parameter int unsigned EXT_REF_HZ = 32'd4000000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Debug request pin
    input wire logic background_debug_i,
    // Clock control outputs
    output logic [1:0] system_clock_sel_o,
    output logic pll_enable_o,
    output logic fll_enable_o,
    output logic fll_low_power_o,
    output logic fll_open_loop_o,
    output logic [1:0] debug_link_clock_sel_o,
    output logic debug_link_clock_avail_o,
    output logic ext_ref_enable_o,
    output logic osc_crystal_o,
    output logic [2:0] pll_ref_div_log2_o,
    output logic pll_ref_divide_by_32_option_o,
    output logic [5:0] pll_multiplier_o,
    output cgm_pkg::cgm_mode_t mode_o
);
    import cgm_pkg::*;

    // Register file state
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl1_nxt;
    logic [7:0] ctrl2_r;
    logic [7:0] ctrl2_nxt;
    logic [1:0] dsel_r;
    logic [1:0] dsel_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;

    // Mode and output state
    cgm_mode_t mode_r;
    cgm_mode_t mode_nxt;
    logic [1:0] csel_r;
    logic [1:0] csel_nxt;
    logic pll_en_r;
    logic pll_en_nxt;
    logic fll_en_r;
    logic fll_en_nxt;
    logic fll_lp_r;
    logic fll_lp_nxt;
    logic fll_ol_r;
    logic fll_ol_nxt;
    logic [1:0] dbg_sel_r;
    logic [1:0] dbg_sel_nxt;
    logic band_ok_r;
    logic band_ok_nxt;

    logic bdm_s;

    // Field views
    logic [1:0] src_sel;
    logic [2:0] ref_divider;
    logic iref;
    logic pll_select;
    logic lpb;
    logic d32;
    logic rng;
    logic [3:0] vco;
    logic [1:0] dstat;
    logic [7:0] stat_byte;
    logic req;

    assign src_sel = ctrl1_r[CGM_SRC_POS +: 2];
    assign ref_divider = ctrl1_r[CGM_REF_DIVIDER_POS +: 3];
    assign iref = ctrl1_r[CGM_IREF_POS];
    assign pll_select = ctrl2_r[CGM_PLL_SELECT_POS];
    assign lpb = ctrl2_r[CGM_LPB_POS];
    assign d32 = ctrl2_r[CGM_D32_POS];
    assign rng = ctrl2_r[CGM_RNG_POS];
    assign vco = ctrl2_r[CGM_VCO_POS +: 4];

    // Debug request crosses in from its pin
    cgm_sync #(
        .W(1)
    ) u_bdm_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(background_debug_i),
        .q_o(bdm_s)
    );

    // True when the divided external reference falls inside the PLL band.
    // 64-bit products: the full divide reaches 4096, which overflows 32 bits.
    function automatic logic band_ok(input logic [2:0] div_log2, input logic hi_rng,
                                     input logic divide_by_32_option);
        longint divisor;
        longint f;
        begin
            divisor = longint'(64'd1) << div_log2;
            if (hi_rng && divide_by_32_option) begin
                divisor = divisor << CGM_D32_SHIFT;
            end
            f = longint'(EXT_REF_HZ);
            band_ok = (f >= CGM_BAND_MIN_HZ * divisor) && (f <= CGM_BAND_MAX_HZ * divisor);
        end
    endfunction : band_ok

    // Mode decode from the control fields and the debug state
    function automatic cgm_mode_t decode_mode(input logic [1:0] src, input logic ir,
                                              input logic ps, input logic lp,
                                              input logic bok, input logic dbg);
        begin
            decode_mode = MODE_OTHER;
            if (src == CGM_SRC_EXT && !ir && lp) begin
                decode_mode = MODE_LP_EXT;
            end else if (src == CGM_SRC_EXT && !ir && ps && !lp && bok) begin
                decode_mode = MODE_PLL_BYP_EXT;
            end else if (src == CGM_SRC_INT && ir && !ps && lp) begin
                // Debug wins over low power: the link needs a clock to talk
                decode_mode = dbg ? MODE_FLL_BYP_INT : MODE_LP_INT;
            end else if (src == CGM_SRC_INT && ir) begin
                decode_mode = MODE_FLL_BYP_INT;
            end
        end
    endfunction : decode_mode

    // Mode, clock selects and enables
    always_comb begin
        band_ok_nxt = band_ok(ref_divider, rng, d32);
        mode_nxt = decode_mode(src_sel, iref, pll_select, lpb, band_ok_r, bdm_s);
        csel_nxt = CGM_CSEL_FLL;
        pll_en_nxt = 1'b0;
        fll_en_nxt = 1'b1;
        fll_lp_nxt = 1'b0;
        fll_ol_nxt = 1'b0;
        dbg_sel_nxt = CGM_DBG_FLL_DIV2;
        case (mode_nxt)
            MODE_PLL_BYP_EXT: begin
                csel_nxt = CGM_CSEL_EXT;
                pll_en_nxt = 1'b1;
                if (bdm_s) begin
                    fll_ol_nxt = 1'b1;
                    dbg_sel_nxt = CGM_DBG_DCO_DIV2;
                end else begin
                    fll_en_nxt = 1'b0;
                    fll_lp_nxt = 1'b1;
                    dbg_sel_nxt = CGM_DBG_NONE;
                end
            end
            MODE_LP_INT: begin
                csel_nxt = CGM_CSEL_INT;
                fll_en_nxt = 1'b0;
                fll_lp_nxt = 1'b1;
                dbg_sel_nxt = CGM_DBG_NONE;
            end
            MODE_LP_EXT: begin
                csel_nxt = CGM_CSEL_EXT;
                fll_en_nxt = 1'b0;
                fll_lp_nxt = 1'b1;
                dbg_sel_nxt = CGM_DBG_NONE;
            end
            MODE_FLL_BYP_INT: begin
                csel_nxt = CGM_CSEL_INT;
            end
            MODE_OTHER: begin
                // Modes outside this block: follow the source field loosely
                if (src_sel == CGM_SRC_EXT) begin
                    csel_nxt = CGM_CSEL_EXT;
                end else if (src_sel == CGM_SRC_INT) begin
                    csel_nxt = CGM_CSEL_INT;
                end else if (pll_select) begin
                    csel_nxt = CGM_CSEL_PLL;
                end
                pll_en_nxt = pll_select;
            end
            default: begin
                csel_nxt = CGM_CSEL_INT;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= MODE_OTHER;
            csel_r <= CGM_CSEL_INT;
            pll_en_r <= 1'b0;
            fll_en_r <= 1'b1;
            fll_lp_r <= 1'b0;
            fll_ol_r <= 1'b0;
            dbg_sel_r <= CGM_DBG_NONE;
            band_ok_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            csel_r <= csel_nxt;
            pll_en_r <= pll_en_nxt;
            fll_en_r <= fll_en_nxt;
            fll_lp_r <= fll_lp_nxt;
            fll_ol_r <= fll_ol_nxt;
            dbg_sel_r <= dbg_sel_nxt;
            band_ok_r <= band_ok_nxt;
        end
    end

    // Range status hides the selection in PLL-bypassed external and low-power internal modes
    always_comb begin
        if (mode_r == MODE_PLL_BYP_EXT || mode_r == MODE_LP_INT) begin
            dstat = 2'h0;
        end else begin
            dstat = dsel_r;
        end
        stat_byte = 8'h00;
        stat_byte[CGM_MODE_POS +: 3] = mode_r;
        stat_byte[CGM_BAND_POS] = band_ok_r;
        stat_byte[CGM_PLLEN_POS] = pll_en_r;
        stat_byte[CGM_FLLEN_POS] = fll_en_r;
        stat_byte[CGM_CSEL_POS +: 2] = csel_r;
    end

    // Wishbone slave: ack one cycle after the request; writes land on the ack edge
    // so the register changes exactly when the master sees the answer.
    assign req = wb_cyc_i && wb_stb_i;

    always_comb begin
        ack_nxt = req && !ack_r;
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        dsel_nxt = dsel_r;
        rdat_nxt = rdat_r;
        if (req && !ack_r) begin
            case (wb_adr_i)
                CGM_CTRL1_OFS: rdat_nxt = {24'h000000, ctrl1_r};
                CGM_CTRL2_OFS: rdat_nxt = {24'h000000, ctrl2_r};
                CGM_CTRL3_OFS: rdat_nxt = {28'h0000000, dstat, dsel_r};
                CGM_STAT_OFS: rdat_nxt = {24'h000000, stat_byte};
                default: rdat_nxt = 32'h00000000; // Unmapped reads as zero
            endcase
        end
        if (req && ack_r && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                CGM_CTRL1_OFS: ctrl1_nxt = wb_dat_i[7:0];
                CGM_CTRL2_OFS: ctrl2_nxt = wb_dat_i[7:0];
                CGM_CTRL3_OFS: dsel_nxt = wb_dat_i[CGM_DSEL_POS +: 2];
                default: ctrl1_nxt = ctrl1_r; // Status and unmapped writes dropped
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_r <= CGM_CTRL1_RST;
            ctrl2_r <= CGM_CTRL2_RST;
            dsel_r <= CGM_DSEL_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            dsel_r <= dsel_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // Outputs, all from flops
    assign system_clock_sel_o = csel_r;
    assign pll_enable_o = pll_en_r;
    assign fll_enable_o = fll_en_r;
    assign fll_low_power_o = fll_lp_r;
    assign fll_open_loop_o = fll_ol_r;
    assign debug_link_clock_sel_o = dbg_sel_r;
    assign debug_link_clock_avail_o = (dbg_sel_r != CGM_DBG_NONE);
    assign mode_o = mode_r;
    // Crystal versus direct clock only changes the oscillator's drive
    assign ext_ref_enable_o = ctrl1_r[CGM_EREN_POS] || !iref;
    assign osc_crystal_o = ctrl1_r[CGM_XTAL_POS];
    // PLL reference scaling and multiplier (multiplier step of four per code)
    assign pll_ref_div_log2_o = ref_divider;
    assign pll_ref_divide_by_32_option_o = rng && d32;
    assign pll_multiplier_o = {vco, 2'b00};

endmodule : cgm_mode_sel
`default_nettype wire

// file: rtl/cgm_pkg.sv
// Constants, register layout and mode list of the clock generator mode selector.
// Assumes a byte-addressed classic Wishbone slave with 8-bit registers in lane 0.
// Summary of operation
// - Enter PLL-bypassed external on source 10, ext ref, PLL, no low power, band ok.
// - PLL-bypassed external: system clock from external reference, PLL running, unselected.
// - PLL targets reference scaled by divider, range and divide_by_32_option, times VCO multiplier.
// - PLL-bypassed external with debug on: debug link clock is open-loop DCO halved.
// - PLL-bypassed external with debug off: FLL disabled in low-power state.
// - PLL-bypassed external and low-power internal: DCO range status reads zero.
// - Enter low-power internal on source 01, internal ref, no PLL, low power, no debug.
// - Low-power internal mode drives system clock from the internal reference.
// - Low-power internal keeps PLL and FLL off; debug link clock unavailable.
// - Debug becoming active in low-power internal switches to FLL-bypassed internal.
// - Enter low-power external on source 10, external ref, low power, any PLL select.
// - External reference may be a crystal oscillator or a direct external clock.
package cgm_pkg;

    // Register byte offsets
    localparam logic [7:0] CGM_CTRL1_OFS = 8'h00;
    localparam logic [7:0] CGM_CTRL2_OFS = 8'h04;
    localparam logic [7:0] CGM_CTRL3_OFS = 8'h08;
    localparam logic [7:0] CGM_STAT_OFS = 8'h0C;

    // Control 1 fields
    localparam int CGM_SRC_POS = 6;
    localparam int CGM_REF_DIVIDER_POS = 3;
    localparam int CGM_IREF_POS = 2;
    localparam int CGM_XTAL_POS = 1;
    localparam int CGM_EREN_POS = 0;

    // Control 2 fields
    localparam int CGM_PLL_SELECT_POS = 7;
    localparam int CGM_LPB_POS = 6;
    localparam int CGM_D32_POS = 5;
    localparam int CGM_RNG_POS = 4;
    localparam int CGM_VCO_POS = 0;

    // Control 3 fields
    localparam int CGM_DSEL_POS = 0;
    localparam int CGM_DSTAT_POS = 2;

    // Status fields
    localparam int CGM_MODE_POS = 0;
    localparam int CGM_BAND_POS = 3;
    localparam int CGM_PLLEN_POS = 4;
    localparam int CGM_FLLEN_POS = 5;
    localparam int CGM_CSEL_POS = 6;

    // Values after reset: internal reference selected, VCO code 1 (multiplier 4)
    localparam logic [7:0] CGM_CTRL1_RST = 8'h04;
    localparam logic [7:0] CGM_CTRL2_RST = 8'h01;
    localparam logic [1:0] CGM_DSEL_RST = 2'h0;

    // Clock source select encodings
    localparam logic [1:0] CGM_SRC_LOOP = 2'h0;
    localparam logic [1:0] CGM_SRC_INT = 2'h1;
    localparam logic [1:0] CGM_SRC_EXT = 2'h2;

    // Selector codes driven to the clock mux
    localparam logic [1:0] CGM_CSEL_FLL = 2'h0;
    localparam logic [1:0] CGM_CSEL_INT = 2'h1;
    localparam logic [1:0] CGM_CSEL_EXT = 2'h2;
    localparam logic [1:0] CGM_CSEL_PLL = 2'h3;

    // Debug link clock source codes
    localparam logic [1:0] CGM_DBG_NONE = 2'h0;
    localparam logic [1:0] CGM_DBG_DCO_DIV2 = 2'h1;
    localparam logic [1:0] CGM_DBG_FLL_DIV2 = 2'h2;

    // Reference band after division, and high-range extra divide
    localparam longint CGM_BAND_MIN_HZ = 64'd1000000;
    localparam longint CGM_BAND_MAX_HZ = 64'd2000000;
    localparam int CGM_D32_SHIFT = 5;
    localparam int CGM_VCO_STEP_SHIFT = 2;

    typedef enum logic [2:0] {
        MODE_OTHER,
        MODE_PLL_BYP_EXT,
        MODE_LP_INT,
        MODE_LP_EXT,
        MODE_FLL_BYP_INT
    } cgm_mode_t;

endpackage : cgm_pkg

// file: rtl/cgm_sync.sv
// Two-flop level synchroniser for inputs arriving from outside the bus clock.
// Assumes the inputs are slow levels; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
`default_nettype none
module cgm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule : cgm_sync
`default_nettype wire

// file: verification/cgm_mode_sel_chk.sv
// Checker for the clock generator mode selector, bound to its top module.
// Assumes a single bus clock domain with synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cgm_mode_sel_chk
    import cgm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic background_debug_i,
    input wire logic [1:0] system_clock_sel_o,
    input wire logic pll_enable_o,
    input wire logic fll_enable_o,
    input wire logic fll_low_power_o,
    input wire logic fll_open_loop_o,
    input wire logic [1:0] debug_link_clock_sel_o,
    input wire logic debug_link_clock_avail_o,
    input wire cgm_pkg::cgm_mode_t mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Debug held high while in low-power internal; sync path needs three edges
    sequence s_lpi_dbg;
        (mode_o == MODE_LP_INT && background_debug_i) ##1 background_debug_i [*3];
    endsequence

    a_pbe_clk_src: assert property (mode_o == MODE_PLL_BYP_EXT |->
        system_clock_sel_o == CGM_CSEL_EXT && pll_enable_o) else $error("pbe source");
    a_pbe_fll_off: assert property (mode_o == MODE_PLL_BYP_EXT && !fll_open_loop_o |->
        fll_low_power_o && !fll_enable_o) else $error("pbe fll state");
    a_pbe_dbg_link: assert property (mode_o == MODE_PLL_BYP_EXT && fll_open_loop_o |->
        debug_link_clock_sel_o == CGM_DBG_DCO_DIV2) else $error("pbe debug clock");
    a_lpi_all_off: assert property (mode_o == MODE_LP_INT |-> system_clock_sel_o == CGM_CSEL_INT
        && !pll_enable_o && !fll_enable_o && !debug_link_clock_avail_o)
        else $error("lpi state");
    a_lpe_all_off: assert property (mode_o == MODE_LP_EXT |-> system_clock_sel_o == CGM_CSEL_EXT
        && !pll_enable_o && !fll_enable_o) else $error("lpe state");
    a_lpi_dbg_fbi: assert property (s_lpi_dbg |-> ##[0:2] mode_o == MODE_FLL_BYP_INT)
        else $error("no switch to fbi");
    a_ack_one_cyc: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack late");
    a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read upper bits");
endmodule : cgm_mode_sel_chk

bind cgm_mode_sel cgm_mode_sel_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .background_debug_i(background_debug_i), .system_clock_sel_o(system_clock_sel_o),
    .pll_enable_o(pll_enable_o), .fll_enable_o(fll_enable_o),
    .fll_low_power_o(fll_low_power_o), .fll_open_loop_o(fll_open_loop_o),
    .debug_link_clock_sel_o(debug_link_clock_sel_o),
    .debug_link_clock_avail_o(debug_link_clock_avail_o), .mode_o(mode_o));
`default_nettype wire

// file: verification/cgm_mode_sel_tb_top.sv
// Self-checking bench for the clock generator mode selector.
// Assumes the 4 MHz default external reference; drives Wishbone and the debug pin.
`timescale 1ns/1ps
`default_nettype none
module cgm_mode_sel_tb_top;
    import cgm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, background_debug_i = 1'b0;
    logic [1:0] system_clock_sel_o, debug_link_clock_sel_o;
    logic pll_enable_o, fll_enable_o, fll_low_power_o, fll_open_loop_o;
    logic debug_link_clock_avail_o, ext_ref_enable_o, osc_crystal_o, pll_ref_divide_by_32_option_o;
    logic [2:0] pll_ref_div_log2_o;
    logic [5:0] pll_multiplier_o;
    cgm_mode_t mode_o;
    int bad_count = 0, total_checks = 0, cyc_count = 0;
    logic [31:0] rd;

    cgm_mode_sel i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .background_debug_i(background_debug_i), .system_clock_sel_o(system_clock_sel_o),
        .pll_enable_o(pll_enable_o), .fll_enable_o(fll_enable_o),
        .fll_low_power_o(fll_low_power_o), .fll_open_loop_o(fll_open_loop_o),
        .debug_link_clock_sel_o(debug_link_clock_sel_o),
        .debug_link_clock_avail_o(debug_link_clock_avail_o),
        .ext_ref_enable_o(ext_ref_enable_o), .osc_crystal_o(osc_crystal_o),
        .pll_ref_div_log2_o(pll_ref_div_log2_o), .pll_ref_divide_by_32_option_o(pll_ref_divide_by_32_option_o),
        .pll_multiplier_o(pll_multiplier_o), .mode_o(mode_o));

    // 40 MHz bus clock
    always #12.5 clk_i = ~clk_i;

    // Hang guard: all tests finish well inside this many cycles
    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 3000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Classic single cycle; held until ack, data taken at that edge
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                           input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_xfer(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        wb_xfer(1'b0, a, 8'h00, 4'h1);
        check(rd, {24'h000000, exp});
    endtask : rd_chk

    // Let the mode path settle, then compare mode, source and enables
    task automatic out_chk(input cgm_mode_t m, input logic [1:0] s, input logic p,
                           input logic f);
        repeat (5) @(posedge clk_i);
        check({25'h0, mode_o, system_clock_sel_o, pll_enable_o, fll_enable_o},
              {25'h0, m, s, p, f});
    endtask : out_chk

    task automatic set_dbg(input logic v);
        @(posedge clk_i);
        background_debug_i <= v;
        repeat (5) @(posedge clk_i);
    endtask : set_dbg

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place, byte lane refused
        rd_chk(CGM_CTRL1_OFS, CGM_CTRL1_RST);
        rd_chk(CGM_CTRL2_OFS, CGM_CTRL2_RST);
        wr(8'h10, 8'h5A);
        rd_chk(8'h10, 8'h00);
        wb_xfer(1'b1, CGM_CTRL1_OFS, 8'hFF, 4'h2);
        rd_chk(CGM_CTRL1_OFS, CGM_CTRL1_RST);
        $display("test reset done");
        // Divider leaves 4 MHz out of band, then 2 MHz enters bypassed external
        wr(CGM_CTRL1_OFS, 8'h80);
        wr(CGM_CTRL2_OFS, 8'h81);
        out_chk(MODE_OTHER, CGM_CSEL_EXT, 1'b1, 1'b1);
        wr(CGM_CTRL1_OFS, 8'h88);
        out_chk(MODE_PLL_BYP_EXT, CGM_CSEL_EXT, 1'b1, 1'b0);
        check({31'h0, fll_low_power_o}, 32'h1);
        check({23'h0, pll_ref_div_log2_o, pll_multiplier_o}, {23'h0, 3'h1, 6'h04});
        rd_chk(CGM_STAT_OFS, 8'h99);
        wr(CGM_CTRL3_OFS, 8'h03);
        rd_chk(CGM_CTRL3_OFS, 8'h03);
        wr(CGM_CTRL1_OFS, 8'h8A);
        out_chk(MODE_PLL_BYP_EXT, CGM_CSEL_EXT, 1'b1, 1'b0);
        check({30'h0, osc_crystal_o, ext_ref_enable_o}, 32'h3);
        // High range with divide-by-32 pushes 4 MHz far below the band
        wr(CGM_CTRL2_OFS, 8'hB1);
        out_chk(MODE_OTHER, CGM_CSEL_EXT, 1'b1, 1'b1);
        check({31'h0, pll_ref_divide_by_32_option_o}, 32'h1);
        wr(CGM_CTRL2_OFS, 8'h81);
        out_chk(MODE_PLL_BYP_EXT, CGM_CSEL_EXT, 1'b1, 1'b0);
        $display("test pll bypassed external done");
        set_dbg(1'b1);
        check({29'h0, fll_open_loop_o, debug_link_clock_sel_o},
              {29'h0, 1'b1, CGM_DBG_DCO_DIV2});
        set_dbg(1'b0);
        $display("test debug clock done");
        // Low-power external with either PLL select
        wr(CGM_CTRL2_OFS, 8'hC1);
        out_chk(MODE_LP_EXT, CGM_CSEL_EXT, 1'b0, 1'b0);
        wr(CGM_CTRL2_OFS, 8'h41);
        out_chk(MODE_LP_EXT, CGM_CSEL_EXT, 1'b0, 1'b0);
        // Range status is only hidden in the two listed modes, so it shows here
        rd_chk(CGM_CTRL3_OFS, 8'h0F);
        $display("test low power external done");
        // Low-power internal, then debug forces the FLL-bypassed internal mode
        wr(CGM_CTRL1_OFS, 8'h44);
        out_chk(MODE_LP_INT, CGM_CSEL_INT, 1'b0, 1'b0);
        check({31'h0, debug_link_clock_avail_o}, 32'h0);
        rd_chk(CGM_CTRL3_OFS, 8'h03);
        set_dbg(1'b1);
        check({29'h0, mode_o}, {29'h0, MODE_FLL_BYP_INT});
        set_dbg(1'b0);
        check({29'h0, mode_o}, {29'h0, MODE_LP_INT});
        $display("test low power internal done");
        close_out();
    end
endmodule : cgm_mode_sel_tb_top
`default_nettype wire
